// ### inc/endec_cfg.svh
// timing and layout constants for the 10 Mb/s manchester encoder/decoder
`ifndef ENDEC_CFG_SVH
`define ENDEC_CFG_SVH

// ==========================================================================
// reference clock and bit cell
`define REF_PERIOD_NS   5
`define BIT_TIME_NS     100
`define BIT_CYC         (`BIT_TIME_NS / `REF_PERIOD_NS)
`define HALF_CYC        (`BIT_CYC / 2)
`define NIB_LAST        3

// ==========================================================================
// receive timing
// earliest accepted mid-bit transition after the previous one (least time, round up)
`define MID_WIN_NS      75
`define MID_WIN_CYC     ((`MID_WIN_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
// no mid-bit transition for this long ends the frame (longest time, round down)
`define EOF_NS          150
`define EOF_CYC         (`EOF_NS / `REF_PERIOD_NS)
`define TAIL_BITS       5
`define TAIL_CYC        (`TAIL_BITS * `BIT_CYC)
// longest excursion still taken as a link pulse (round down)
`define LP_MAX_NS       200
`define LP_MAX_CYC      (`LP_MAX_NS / `REF_PERIOD_NS)
`define BAD_POL_PULSES  3

// ==========================================================================
// transmit timing
`define LP_WIDTH_NS     100
`define LP_WIDTH_CYC    ((`LP_WIDTH_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define LINK_PERIOD_MS  16
`define LINK_PERIOD_CYC (`LINK_PERIOD_MS * 1000000 / `REF_PERIOD_NS)
// line held high after the end of the last cell
`define HOLD_NS         200
`define HOLD_CYC        ((`HOLD_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)

`endif

// ### inc/endec_pkg.sv
// types shared by the manchester encoder/decoder and its buffer
package endec_pkg;

  // ========================================================================
  // word passed from the mac domain to the serializer
  typedef struct packed {
    logic       eof;
    logic [3:0] nib;
  } tx_word_s;

  // ========================================================================
  // state encodings
  typedef enum logic [2:0] {
    R_IDLE  = 3'b001,
    R_PULSE = 3'b010,
    R_DATA  = 3'b100
  } rx_state_e;

  typedef enum logic [3:0] {
    T_IDLE = 4'b0001,
    T_BIT  = 4'b0010,
    T_HOLD = 4'b0100,
    T_LINK = 4'b1000
  } tx_state_e;

  // ========================================================================
  // module state records
  typedef struct packed {
    tx_word_s [1:0] mem;
    logic           wr;
    logic           rd;
    logic [1:0]     cnt;
  } buf_state_s;

  typedef struct packed {
    logic     tx_ready;
    logic     busy;
    logic     in_frame;
    logic     req;
    logic     ack_s1;
    logic     ack_s2;
    logic     ack_seen;
    tx_word_s word;
  } mac_state_s;

  typedef struct packed {
    logic        fd_s1;
    logic        fd_s2;
    logic        hi_s1;
    logic        hi_s2;
    logic        lo_s1;
    logic        lo_s2;
    logic        req_s1;
    logic        req_s2;
    logic        req_seen;
    logic        ack;
    tx_state_e   ts;
    logic [3:0]  nib;
    logic [1:0]  bidx;
    logic [5:0]  tcnt;
    logic [21:0] link_t;
    logic        lvl;
    logic [3:0]  ecnt;
    logic        tx_pos;
    logic        tx_neg;
    logic        tx_emph;
    rx_state_e   rs;
    logic [5:0]  pcnt;
    logic        pulse_inv;
    logic        lvl_d;
    logic        inv;
    logic [1:0]  bad_cnt;
    logic        bad_polarity;
    logic        rx_crs;
    logic [6:0]  tail;
    logic [3:0]  cdiv;
    logic        rx_clk;
    logic        rx_bit;
    logic        rx_bit_valid;
    logic        crs;
  } ref_state_s;

endpackage

// ### design/two_entry_buffer.sv
// two-entry word buffer between the domain crossing and the serializer
module two_entry_buffer
  import endec_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // filling side
  input  wire logic in_valid,
  output logic      in_ready,
  input  tx_word_s  in_data,
  // draining side
  output logic      out_valid,
  input  wire logic out_ready,
  output tx_word_s  out_data
);

  buf_state_s b;
  buf_state_s next_b;
  logic       push;
  logic       pop;

  // ========================================================================
  // flags and next state
  always_comb begin
    next_b    = b;
    in_ready  = (b.cnt != 2'd2);
    out_valid = (b.cnt != 2'd0);
    out_data  = b.mem[b.rd];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    if (push) begin
      next_b.mem[b.wr] = in_data;
      next_b.wr        = ~b.wr;
    end
    if (pop) begin
      next_b.rd = ~b.rd;
    end
    next_b.cnt = 2'(b.cnt + {1'b0, push} - {1'b0, pop});
  end

  // ========================================================================
  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      b <= '0;
    end else begin
      b <= next_b;
    end
  end

endmodule // two_entry_buffer

// ### design/tenbase_t_manchester_endec.sv
// 10 Mb/s manchester encoder/decoder with link pulse polarity correction
`include "endec_cfg.svh"

// How it works
// - three consecutive inverted link pulses received report bad polarity.
// - bad polarity stays latched in a status bit until cleared.
// - after detection the receive pair is swapped internally, data keeps decoding.
// - encoding starts when transmit enable rises and stops when it falls.
// - every frame ends positive: mid-cell after a one, cell end after a zero.
// - a digital phase tracker recovers bit clock and data from the stream.
// - end of frame is declared when expected mid-bit transitions stop.
// - carrier sense drops within one and a half bit times after last bit.
// - receive clock keeps toggling five bit times after carrier sense drops.
// - with no data, a 100 ns link pulse is sent every 16 ms.
// - half duplex carrier covers transmit and receive; full duplex receive only.
module tenbase_t_manchester_endec
  import endec_pkg::*;
#(
  parameter int unsigned LINK_PERIOD = `LINK_PERIOD_CYC
) (
  // reference clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // mac link clock and transmit words
  input  wire logic       mac_clk,
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  output logic            tx_ready,
  // configuration and status
  input  wire logic       full_duplex,
  input  wire logic       bad_polarity_clear,
  output logic            bad_polarity,
  // twisted pair line
  input  wire logic       line_hi,
  input  wire logic       line_lo,
  output logic            tx_pos,
  output logic            tx_neg,
  output logic            tx_emph,
  // receive side towards the mac
  output logic            crs,
  output logic            rx_clk,
  output logic            rx_bit,
  output logic            rx_bit_valid
);

  localparam mac_state_s MAC_RST = '{default: '0};
  localparam ref_state_s REF_RST = '{ts: T_IDLE, rs: R_IDLE, default: '0};

  mac_state_s m;
  mac_state_s next_m;
  ref_state_s r;
  ref_state_s next_r;

  logic       buf_in_valid;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic       buf_pop;
  tx_word_s   buf_out;

  function automatic logic [5:0] sat_inc6(input logic [5:0] v);
    sat_inc6 = (v == 6'h3f) ? v : 6'(v + 6'h01);
  endfunction

  function automatic logic [3:0] sat_inc4(input logic [3:0] v);
    sat_inc4 = (v == 4'hf) ? v : 4'(v + 4'h1);
  endfunction

  // ==========================================================================
  // mac domain: take nibbles and the end of frame, hand them over by toggle
  // the word register stays still while busy, so the far side may read it
  // directly once it sees the toggle.
  always_comb begin
    next_m        = m;
    next_m.ack_s1 = r.ack;
    next_m.ack_s2 = m.ack_s1;
    if (m.ack_s2 != m.ack_seen) begin
      next_m.ack_seen = m.ack_s2;
      next_m.busy     = 1'b0;
    end
    if (m.tx_ready) begin
      if (tx_en) begin
        next_m.word     = '{eof: 1'b0, nib: txd};
        next_m.busy     = 1'b1;
        next_m.req      = ~m.req;
        next_m.in_frame = 1'b1;
      end else if (m.in_frame) begin
        next_m.word     = '{eof: 1'b1, nib: 4'h0};
        next_m.busy     = 1'b1;
        next_m.req      = ~m.req;
        next_m.in_frame = 1'b0;
      end
    end
    next_m.tx_ready = ~next_m.busy;
  end

  always_ff @(posedge mac_clk or negedge rst_n) begin
    if (!rst_n) begin
      m <= MAC_RST;
    end else begin
      m <= next_m;
    end
  end

  // ==========================================================================
  // word buffer; a full buffer holds back the ack and so the mac's ready
  two_entry_buffer u_buf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (m.word),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out)
  );

  assign buf_in_valid = (r.req_s2 != r.req_seen);

  // ==========================================================================
  // reference domain: crossing, transmit serializer and receive decoder
  logic       chi;
  logic       clo;
  logic       neutral;
  logic       cur_bit;
  logic       bad_set;
  logic       tx_active;

  always_comb begin
    next_r        = r;
    buf_pop       = 1'b0;
    bad_set       = 1'b0;
    cur_bit       = 1'b0;

    // synchronisers
    next_r.fd_s1  = full_duplex;
    next_r.fd_s2  = r.fd_s1;
    next_r.hi_s1  = line_hi;
    next_r.hi_s2  = r.hi_s1;
    next_r.lo_s1  = line_lo;
    next_r.lo_s2  = r.lo_s1;
    next_r.req_s1 = m.req;
    next_r.req_s2 = r.req_s1;

    if (buf_in_valid && buf_in_ready) begin
      next_r.req_seen = r.req_s2;
      next_r.ack      = ~r.ack;
    end

    // ------------------------------------------------------------------------
    // transmit
    unique case (r.ts)
      T_IDLE: begin
        next_r.link_t = 22'(r.link_t + 22'd1);
        if (buf_out_valid) begin
          buf_pop       = 1'b1;
          next_r.link_t = '0;
          if (!buf_out.eof) begin
            next_r.ts   = T_BIT;
            next_r.nib  = buf_out.nib;
            next_r.bidx = '0;
            next_r.tcnt = '0;
          end
        end else if (r.link_t >= 22'(LINK_PERIOD - 1)) begin
          next_r.ts     = T_LINK;
          next_r.tcnt   = '0;
          next_r.link_t = '0;
        end
      end
      T_BIT: begin
        next_r.tcnt = 6'(r.tcnt + 6'd1);
        if (r.tcnt == 6'(`BIT_CYC - 1)) begin
          next_r.tcnt = '0;
          if (r.bidx != 2'(`NIB_LAST)) begin
            next_r.bidx = 2'(r.bidx + 2'd1);
          end else if (buf_out_valid && !buf_out.eof) begin
            buf_pop     = 1'b1;
            next_r.nib  = buf_out.nib;
            next_r.bidx = '0;
          end else begin
            // end of frame, or an underrun which also ends it
            buf_pop   = buf_out_valid;
            next_r.ts = T_HOLD;
          end
        end
      end
      T_HOLD: begin
        next_r.tcnt = 6'(r.tcnt + 6'd1);
        if (r.tcnt == 6'(`HOLD_CYC - 1)) begin
          next_r.ts   = T_IDLE;
          next_r.tcnt = '0;
        end
      end
      T_LINK: begin
        // the pulse itself counts toward the link period, so pulses start every period
        next_r.link_t = 22'(r.link_t + 22'd1);
        next_r.tcnt = 6'(r.tcnt + 6'd1);
        if (r.tcnt == 6'(`LP_WIDTH_CYC - 1)) begin
          next_r.ts   = T_IDLE;
          next_r.tcnt = '0;
        end
      end
    endcase

    // first half carries the complement, so one rises mid-cell, zero falls
    cur_bit = next_r.nib[next_r.bidx];
    if (next_r.ts == T_BIT) begin
      next_r.lvl = (next_r.tcnt < 6'(`HALF_CYC)) ? ~cur_bit : cur_bit;
    end else begin
      // hold after the last cell: a one is already high, a zero rises here
      next_r.lvl = (next_r.ts == T_HOLD) || (next_r.ts == T_LINK);
    end
    next_r.tx_pos  = next_r.lvl;
    next_r.tx_neg  = (next_r.ts == T_BIT) && !next_r.lvl;
    // pre-emphasis: boost for half a cell after each change to a driven level, none on the return to idle
    next_r.ecnt    = ({next_r.tx_pos, next_r.tx_neg} != {r.tx_pos, r.tx_neg}) ? 4'h0
                   : sat_inc4(r.ecnt);
    next_r.tx_emph = (next_r.ts != T_IDLE) && (next_r.ecnt < 4'(`HALF_CYC));
    tx_active      = (next_r.ts == T_BIT) || (next_r.ts == T_HOLD);

    // ------------------------------------------------------------------------
    // receive; the pair is swapped once reversed polarity is found
    chi     = r.inv ? r.lo_s2 : r.hi_s2;
    clo     = r.inv ? r.hi_s2 : r.lo_s2;
    neutral = !chi && !clo;
    next_r.rx_bit_valid = 1'b0;
    next_r.tail         = (r.tail != 7'd0) ? 7'(r.tail - 7'd1) : 7'd0;

    unique case (r.rs)
      R_IDLE: begin
        if (!neutral) begin
          next_r.rs        = R_PULSE;
          next_r.pcnt      = '0;
          next_r.pulse_inv = clo;
        end
      end
      R_PULSE: begin
        next_r.pcnt = sat_inc6(r.pcnt);
        if (neutral) begin
          next_r.rs = R_IDLE;
          // a long one-sided excursion is noise and leaves the count alone
          if (r.pcnt < 6'(`LP_MAX_CYC)) begin
            if (r.pulse_inv) begin
              if (r.bad_cnt == 2'(`BAD_POL_PULSES - 1)) begin
                next_r.inv     = ~r.inv;
                bad_set        = 1'b1;
                next_r.bad_cnt = '0;
              end else begin
                next_r.bad_cnt = 2'(r.bad_cnt + 2'd1);
              end
            end else begin
              next_r.bad_cnt = '0;
            end
          end
        end else if (r.pulse_inv ? chi : clo) begin
          // both polarities seen without a pause: this is data
          next_r.rs     = R_DATA;
          next_r.pcnt   = '0;
          next_r.lvl_d  = chi;
          next_r.rx_crs = 1'b1;
        end
      end
      R_DATA: begin
        next_r.pcnt  = sat_inc6(r.pcnt);
        next_r.lvl_d = chi;
        if ((chi != r.lvl_d) && (r.pcnt >= 6'(`MID_WIN_CYC - 1))) begin
          // transitions nearer than the window are cell boundaries
          next_r.pcnt         = '0;
          next_r.rx_bit       = chi;
          next_r.rx_bit_valid = 1'b1;
          next_r.cdiv         = '0;
          next_r.rx_clk       = 1'b0;
        end else if (r.pcnt >= 6'(`EOF_CYC - 1)) begin
          next_r.rs     = R_IDLE;
          next_r.rx_crs = 1'b0;
          next_r.tail   = 7'(`TAIL_CYC);
          next_r.pcnt   = '0;
        end
      end
    endcase

    // recovered clock runs through the frame and the tail after it
    if (!next_r.rx_bit_valid) begin
      if (next_r.rx_crs || (next_r.tail != 7'd0)) begin
        next_r.cdiv = 4'(r.cdiv + 4'd1);
        if (r.cdiv == 4'(`HALF_CYC - 1)) begin
          next_r.cdiv   = '0;
          next_r.rx_clk = ~r.rx_clk;
        end
      end else begin
        next_r.cdiv   = '0;
        next_r.rx_clk = 1'b0;
      end
    end

    // a new detection wins over a clear in the same cycle
    next_r.bad_polarity = bad_set || (r.bad_polarity && !bad_polarity_clear);
    next_r.crs          = next_r.rx_crs || (tx_active && !r.fd_s2);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= REF_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs, all straight from flip-flops
  assign tx_ready     = m.tx_ready;
  assign bad_polarity = r.bad_polarity;
  assign tx_pos       = r.tx_pos;
  assign tx_neg       = r.tx_neg;
  assign tx_emph      = r.tx_emph;
  assign crs          = r.crs;
  assign rx_clk       = r.rx_clk;
  assign rx_bit       = r.rx_bit;
  assign rx_bit_valid = r.rx_bit_valid;

endmodule // tenbase_t_manchester_endec

// ### bench/endec_props.sv
// port checker for the manchester encoder/decoder, bound to its top
module endec_props
  import endec_pkg::*;
#(
  parameter int unsigned LINK_PERIOD = 400
) (
  // clocks and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       mac_clk,
  // mac transmit side
  input wire logic       tx_en,
  input wire logic [3:0] txd,
  input wire logic       tx_ready,
  // configuration and status
  input wire logic       full_duplex,
  input wire logic       bad_polarity_clear,
  input wire logic       bad_polarity,
  // line
  input wire logic       line_hi,
  input wire logic       line_lo,
  input wire logic       tx_pos,
  input wire logic       tx_neg,
  input wire logic       tx_emph,
  // receive side
  input wire logic       crs,
  input wire logic       rx_clk,
  input wire logic       rx_bit,
  input wire logic       rx_bit_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // cycles since the last decoded bit, parked at all ones when quiet
  logic [7:0] since_bit;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_bit <= 8'hff;
    end else if (rx_bit_valid) begin
      since_bit <= 8'h00;
    end else if (since_bit != 8'hff) begin
      since_bit <= since_bit + 8'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // assertions
  a_line_exclusive: assert property (!(tx_pos && tx_neg))
    else $error("both line drives active");
  a_neg_half_cell: assert property ($rose(tx_neg) |=> tx_neg [*8])
    else $error("negative half cell too short");
  a_emph_follows: assert property (
    $changed({tx_pos, tx_neg}) && (tx_pos || tx_neg) |-> ##[0:1] tx_emph)
    else $error("no pre-emphasis after line change");
  a_valid_single: assert property (rx_bit_valid |=> !rx_bit_valid [*8])
    else $error("decoded bits too close");
  a_crs_release: assert property (full_duplex && since_bit == 8'd38 |-> !crs)
    else $error("carrier sense held after frame");
  a_tail_clock: assert property ($fell(crs) && full_duplex |-> ##[80:95] $changed(rx_clk))
    else $error("receive clock stopped early");
  a_clock_parks: assert property (since_bit == 8'hff && !crs |-> !rx_clk)
    else $error("receive clock running when idle");
  a_flag_latched: assert property (bad_polarity && !bad_polarity_clear |=> bad_polarity)
    else $error("polarity flag lost");
  a_flag_clears: assert property (bad_polarity_clear && $past(bad_polarity_clear) |-> !bad_polarity)
    else $error("polarity flag not cleared");
  a_crs_on_tx: assert property (!full_duplex && tx_neg |-> ##[0:3] crs)
    else $error("no carrier sense while sending");
  a_fd_tx_quiet: assert property (full_duplex && tx_neg && since_bit == 8'hff |-> !crs)
    else $error("carrier sense on send in full duplex");

  // ==========================================================================
  // covers
  c_flag_set: cover property ($rose(bad_polarity));
  c_rx_end: cover property ($fell(crs) && full_duplex);
  c_hd_send: cover property (!full_duplex && tx_neg && crs);
endmodule // endec_props

bind tenbase_t_manchester_endec endec_props #(.LINK_PERIOD(LINK_PERIOD)) props_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .mac_clk(mac_clk), .tx_en(tx_en), .txd(txd),
  .tx_ready(tx_ready), .full_duplex(full_duplex), .bad_polarity_clear(bad_polarity_clear),
  .bad_polarity(bad_polarity), .line_hi(line_hi), .line_lo(line_lo), .tx_pos(tx_pos),
  .tx_neg(tx_neg), .tx_emph(tx_emph), .crs(crs), .rx_clk(rx_clk), .rx_bit(rx_bit),
  .rx_bit_valid(rx_bit_valid)
);

// ### bench/mac_model.sv
// behavioural mac transmit side handing nibbles to the endec
module mac_model (
  // link clock and reset
  input  wire logic       mac_clk,
  input  wire logic       rst_n,
  // transmit words
  input  wire logic       tx_ready,
  output logic            tx_en,
  output logic [3:0]      txd
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    tx_en = 1'b0;
    txd   = 4'h0;
  end

  // a word is only taken on a ready edge, so it is held until one passes
  task automatic send_frame(input logic [3:0] nibs[$], input int idle);
    repeat (idle) @(posedge mac_clk);
    foreach (nibs[i]) begin
      tx_en <= 1'b1;
      txd   <= nibs[i];
      @(posedge mac_clk);
      while (tx_ready !== 1'b1) @(posedge mac_clk);
    end
    // end of frame; stale data is scrambled so nothing relies on it
    tx_en <= 1'b0;
    txd   <= ~txd;
    @(posedge mac_clk);
    while (tx_ready !== 1'b1) @(posedge mac_clk);
  endtask
endmodule // mac_model

// ### bench/tenbase_t_manchester_endec_tb_top.sv
// self-checking bench for the manchester encoder/decoder
`define CHK(n, e, s) begin \
  comparisons++; \
  if ((s) !== (e)) begin \
    fails++; \
    $display("[FAIL] %s expected %h seen %h", n, e, s); \
  end \
end

module tenbase_t_manchester_endec_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int          LP  = 400;
  localparam logic [11:0] PAT = 12'h9d6;

  logic       ref_clk, mac_clk, rst_n, full_duplex, bad_polarity_clear;
  logic       line_hi, line_lo, tx_en, tx_ready, bad_polarity, tx_pos, tx_neg;
  logic       tx_emph, crs, rx_clk, rx_bit, rx_bit_valid;
  logic [3:0] txd;
  logic [3:0] q[$];
  logic       rxq[$];
  int         fails, comparisons, cyc;

  tenbase_t_manchester_endec #(.LINK_PERIOD(LP)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .mac_clk(mac_clk), .tx_en(tx_en), .txd(txd),
    .tx_ready(tx_ready), .full_duplex(full_duplex), .bad_polarity_clear(bad_polarity_clear),
    .bad_polarity(bad_polarity), .line_hi(line_hi), .line_lo(line_lo), .tx_pos(tx_pos),
    .tx_neg(tx_neg), .tx_emph(tx_emph), .crs(crs), .rx_clk(rx_clk), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid));
  mac_model mac (.mac_clk(mac_clk), .rst_n(rst_n), .tx_ready(tx_ready), .tx_en(tx_en),
    .txd(txd));

  // ==========================================================================
  // clocks, bit collector, hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    mac_clk = 1'b0;
    #7;
    forever #32 mac_clk = ~mac_clk;
  end
  always @(posedge ref_clk) begin
    if (rx_bit_valid === 1'b1) rxq.push_back(rx_bit);
    cyc++;
    if (cyc == 30000) begin
      fails++;
      $display("[FAIL] run length expected below limit seen %0d", cyc);
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // line stimulus in the far end's place
  task automatic drive(input logic h, input logic l, input int n);
    line_hi <= h;
    line_lo <= l;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic send_link(input logic inv);
    drive(!inv, inv, 20);
    drive(1'b0, 1'b0, 100);
  endtask

  // scenarios
  task automatic t_link();
    realtime tr;
    @(posedge tx_pos);
    tr = $realtime;
    @(negedge tx_pos);
    `CHK("link width", 20, int'(($realtime - tr) / 5.0))
    @(posedge tx_pos);
    `CHK("link period", 1'b1, int'(($realtime - tr) / 5.0) inside {[LP-1:LP+1]})
  endtask

  task automatic t_tx(input logic [3:0] n[$], input logic fd);
    int t;
    logic b;
    full_duplex <= fd;
    @(negedge tx_pos);
    `CHK("ready idle", 1'b1, tx_ready)
    fork
      mac.send_frame(n, 2);
    join_none
    t = 0;
    while (tx_pos !== 1'b1 && tx_neg !== 1'b1 && t < 300) begin
      @(posedge ref_clk);
      t++;
    end
    for (int k = 0; k < 4 * n.size(); k++) begin
      b = n[k / 4][k % 4];
      repeat ((k == 0) ? 14 : 20) @(posedge ref_clk);
      `CHK("tx cell", {b, ~b}, {tx_pos, tx_neg})
      if (k == 2) `CHK("crs on send", ~fd, crs)
    end
    repeat (10) @(posedge ref_clk);
    `CHK("final level", 2'b10, {tx_pos, tx_neg})
    repeat (60) @(posedge ref_clk);
    `CHK("line quiet", 2'b00, {tx_pos, tx_neg})
  endtask

  task automatic t_rx(input logic inv);
    logic v;
    rxq.delete();
    for (int i = 0; i < 12; i++) begin
      v = PAT[i] ^ inv;
      drive(!v, v, 10);
      drive(v, !v, 10);
      if (i == 6) `CHK("crs in frame", 1'b1, crs)
    end
    drive(1'b0, 1'b0, 150);
    `CHK("crs after frame", 1'b0, crs)
    `CHK("bit count", 1'b1, rxq.size() >= 10)
    for (int k = 0; k < 10; k++) begin
      `CHK("rx bit", PAT[2 + k], rxq[rxq.size() - 10 + k])
    end
  endtask

  task automatic t_pol();
    logic [5:0] seq;
    seq = 6'b111011;
    for (int i = 0; i < 6; i++) begin
      send_link(seq[i]);
      if (i == 4) `CHK("flag early", 1'b0, bad_polarity)
    end
    `CHK("flag set", 1'b1, bad_polarity)
    t_rx(1'b1);
    `CHK("flag held", 1'b1, bad_polarity)
    bad_polarity_clear <= 1'b1;
    repeat (2) @(posedge ref_clk);
    bad_polarity_clear <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("flag cleared", 1'b0, bad_polarity)
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    full_duplex = 1'b0;
    bad_polarity_clear = 1'b0;
    line_hi = 1'b0;
    line_lo = 1'b0;
    fails = 0;
    comparisons = 0;
    cyc = 0;
    // held over six of the slower clock so both domains see it
    repeat (6) @(posedge mac_clk);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_link();
    q = '{4'h5, 4'ha, 4'h3, 4'hc};
    t_tx(q, 1'b0);
    q = '{4'hf, 4'h7};
    t_tx(q, 1'b1);
    t_rx(1'b0);
    t_pol();
    wrap_up();
  end
endmodule // tenbase_t_manchester_endec_tb_top
